// *** src/bsac_pkg.sv ***
// Purpose: shared constants and carriers for the burst sram access control
// Assumes: 20 MHz mclk, 512k x 32 array
// Notes: lane count and widths are fixed here; the top module may override only the address port width and depth
package bsac_pkg;
    localparam int BSAC_ADDR_W = 19;
    localparam int BSAC_LANES = 4;
    localparam int BSAC_LANE_W = 8;
    localparam int BSAC_DATA_W = BSAC_LANES * BSAC_LANE_W;
    localparam int BSAC_BURST_W = 2;
    // sleep entry and exit take this many cycles
    localparam int BSAC_SLEEP_CYC = 2;
    localparam int BSAC_CLK_PERIOD_NS = 50;
    localparam int BSAC_SLEEP_EXIT_GUARD_NS = 2 * BSAC_CLK_PERIOD_NS;
    localparam int BSAC_SLEEP_EXIT_GUARD_CYC =
        (BSAC_SLEEP_EXIT_GUARD_NS + BSAC_CLK_PERIOD_NS - 1) / BSAC_CLK_PERIOD_NS;
    localparam logic [1:0] BSAC_SLEEP_CNT_MAX = 2'(BSAC_SLEEP_CYC - 1);
    localparam logic [1:0] BSAC_STEP_ONE = 2'h1;
    localparam logic [1:0] BSAC_XOR_2ND = 2'h1;
    localparam logic [1:0] BSAC_XOR_3RD = 2'h2;
    localparam logic [1:0] BSAC_XOR_4TH = 2'h3;

    typedef enum logic [1:0] {
        BSAC_AWAKE = 2'h0,
        BSAC_ENTER = 2'h1,
        BSAC_ASLEEP = 2'h3,
        BSAC_LEAVE = 2'h2
    } bsac_pwr_e;

    // registered synchronous inputs
    typedef struct packed {
        logic [BSAC_ADDR_W-1:0] addr;
        logic chip_sel_primary_n;
        logic chip_sel_high;
        logic chip_sel_third_n;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_qualify_n;
        logic [BSAC_LANES-1:0] byte_lane_select_n;
        logic [BSAC_DATA_W-1:0] wdata;
    } bsac_in_s;

    // request to the memory core
    typedef struct packed {
        logic wr;
        logic [BSAC_LANES-1:0] lane_we;
        logic [BSAC_ADDR_W-1:0] addr;
        logic [BSAC_DATA_W-1:0] wdata;
    } bsac_core_s;
endpackage

// *** src/bsac_top.sv ***
// Purpose: access control of a flow-through common-i/o burst sram
// Assumes: one clock mclk, synchronous active-low rst_n, array held here
// Notes: output enable is combinational by nature; the dq drive enable
//        register is qualified with it after two synchroniser flop stages
`timescale 1ns/1ns

// What this block does
// - all synchronous inputs are registered on the rising clock edge
// - burst order select low gives linear, high or floating interleaved
// - burst start loads first address into two-bit wraparound counter
// - counter seeded from two low address bits; upper address held
// - interleaved order: first value xor 01, 10, 11
// - linear order: low address plus one modulo four
// - counter steps only when advance asserted, else holds
// - global write writes all four lanes regardless of lane selects
// - otherwise write lanes whose select and byte qualifier are both asserted
// - processor strobe ignored when primary chip select is high
// - read starts with all selects active and either strobe low
// - processor-strobe start is always a read; write inputs ignored
// - write enables on the following edge write data to captured address
// - controller strobe with write enables writes in the same cycle
// - data bus released whenever a write is detected
// - output enable acts through a two-flop synchroniser; low drives, high tristates
// - sleep input asynchronous; entry and exit two cycles; data kept
// - access pending at sleep entry may be lost
// - write indication: global write, or qualifier with any lane select
// - both strobes asserted with primary select low: only processor strobe honoured
// - outputs tristated while deselected and first clock after
module bsac_top #(
    parameter int ADDR_W = bsac_pkg::BSAC_ADDR_W,
    parameter int DEPTH = 1 << bsac_pkg::BSAC_ADDR_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bus master pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_high,
    input wire logic chip_sel_third_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_qualify_n,
    input wire logic [bsac_pkg::BSAC_LANES-1:0] byte_lane_select_n,
    input wire logic output_enable_n,
    input wire logic burst_order_sel,
    input wire logic sleep_request,
    // data bus, split into three signals
    input wire logic [bsac_pkg::BSAC_DATA_W-1:0] dq_in,
    output logic [bsac_pkg::BSAC_DATA_W-1:0] dq_out,
    output logic dq_oe,
    // status
    output logic sleeping
);
    import bsac_pkg::*;

    // ------------------------------------------------------------
    // input registers and synchronisers
    // ------------------------------------------------------------
    bsac_in_s pin_q;
    bsac_in_s next_pin_q;
    logic [1:0] sleep_sync;
    logic [1:0] next_sleep_sync;
    logic [1:0] oe_sync;
    logic [1:0] next_oe_sync;
    logic [1:0] mode_sync;
    logic [1:0] next_mode_sync;

    always_comb begin
        next_pin_q = '{addr: addr[BSAC_ADDR_W-1:0],
                       chip_sel_primary_n: chip_sel_primary_n,
                       chip_sel_high: chip_sel_high,
                       chip_sel_third_n: chip_sel_third_n,
                       processor_addr_strobe_n: processor_addr_strobe_n,
                       controller_addr_strobe_n: controller_addr_strobe_n,
                       burst_advance_n: burst_advance_n,
                       global_write_n: global_write_n,
                       byte_write_qualify_n: byte_write_qualify_n,
                       byte_lane_select_n: byte_lane_select_n,
                       wdata: dq_in};
        next_sleep_sync = {sleep_sync[0], sleep_request};
        next_oe_sync = {oe_sync[0], output_enable_n};
        next_mode_sync = {mode_sync[0], burst_order_sel};
    end

    always_ff @(posedge mclk) begin
        pin_q <= next_pin_q;
        sleep_sync <= next_sleep_sync;
        oe_sync <= next_oe_sync;
        mode_sync <= next_mode_sync;
    end

    // ------------------------------------------------------------
    // cycle decode
    // ------------------------------------------------------------
    logic selected;
    logic start_proc;
    logic start_ctrl;
    logic write_ind;
    logic [BSAC_LANES-1:0] lane_we;
    logic awake;

    always_comb begin
        selected = !pin_q.chip_sel_primary_n && pin_q.chip_sel_high
                   && !pin_q.chip_sel_third_n;
        // strobe ignored with primary select high
        start_proc = awake && !pin_q.chip_sel_primary_n && !pin_q.processor_addr_strobe_n;
        // processor strobe has priority, unless primary select voids it
        start_ctrl = awake && !pin_q.controller_addr_strobe_n
                     && (pin_q.processor_addr_strobe_n || pin_q.chip_sel_primary_n);
        write_ind = !pin_q.global_write_n || (!pin_q.byte_write_qualify_n
                    && !(&pin_q.byte_lane_select_n));
    end

    // per-lane write enables
    for (genvar g = 0; g < BSAC_LANES; g++) begin : g_lane
        assign lane_we[g] = !pin_q.global_write_n
                            || (!pin_q.byte_write_qualify_n
                                && !pin_q.byte_lane_select_n[g]);
    end

    // ------------------------------------------------------------
    // burst address
    // ------------------------------------------------------------
    logic [BSAC_ADDR_W-1:0] base_addr;
    logic [BSAC_ADDR_W-1:0] next_base_addr;
    logic [BSAC_BURST_W-1:0] burst_cnt;
    logic [BSAC_BURST_W-1:0] next_burst_cnt;
    logic [BSAC_BURST_W-1:0] burst_low;
    logic active;
    logic next_active;
    logic [BSAC_BURST_W-1:0] step_low;
    logic [BSAC_BURST_W-1:0] use_cnt;

    always_comb begin
        step_low = BSAC_BURST_W'(burst_cnt + BSAC_STEP_ONE);
        use_cnt = burst_cnt;
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_active = active;
        if (selected && (start_proc || start_ctrl)) begin
            next_base_addr = pin_q.addr;
            next_burst_cnt = '0;
            next_active = 1'b1;
        end else if (!awake) begin
            next_active = 1'b0;  // pending access dropped
        end else if ((start_proc || start_ctrl) && !selected) begin
            next_active = 1'b0;
        end else if (!pin_q.burst_advance_n && active) begin
            // the advancing edge already uses the next address
            use_cnt = step_low;
            next_burst_cnt = step_low;
        end
        if (!rst_n) begin
            next_active = 1'b0;
            next_burst_cnt = '0;
        end
        // interleaved: seed xor step count linear: seed plus count
        burst_low = mode_sync[1] ? (base_addr[BSAC_BURST_W-1:0] ^ use_cnt)
                                 : BSAC_BURST_W'(base_addr[BSAC_BURST_W-1:0] + use_cnt);
    end

    always_ff @(posedge mclk) begin
        base_addr <= next_base_addr;
        burst_cnt <= next_burst_cnt;
        active <= next_active;
    end

    // ------------------------------------------------------------
    // core request and array
    // ------------------------------------------------------------
    bsac_core_s req;
    logic [BSAC_DATA_W-1:0] rd_word;
    logic [BSAC_ADDR_W-1:0] cur_addr;

    always_comb begin
        cur_addr = {base_addr[BSAC_ADDR_W-1:BSAC_BURST_W], burst_low};
        req = '{wr: 1'b0, lane_we: '0, addr: cur_addr, wdata: pin_q.wdata};
        if (selected && start_proc) begin
            req.addr = pin_q.addr;  // always a read
        end else if (selected && start_ctrl) begin
            req.addr = pin_q.addr;
            req.wr = write_ind;  // same-cycle write
            req.lane_we = write_ind ? lane_we : '0;
        end else if (active && awake && pin_q.controller_addr_strobe_n
                     && (pin_q.processor_addr_strobe_n || pin_q.chip_sel_primary_n)) begin
            req.wr = write_ind;  // follow-on write to captured address
            req.lane_we = write_ind ? lane_we : '0;
        end
    end

    // one array per lane, so each array has a single writing process
    for (genvar g = 0; g < BSAC_LANES; g++) begin : g_wr
        logic [BSAC_LANE_W-1:0] lane_mem [DEPTH];
        always_ff @(posedge mclk) begin
            if (req.wr && req.lane_we[g]) begin
                lane_mem[req.addr] <= req.wdata[g*BSAC_LANE_W +: BSAC_LANE_W];
            end
        end
        assign rd_word[g*BSAC_LANE_W +: BSAC_LANE_W] = lane_mem[req.addr];
    end

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    bsac_pwr_e pwr;
    bsac_pwr_e next_pwr;
    logic [1:0] pwr_cnt;
    logic [1:0] next_pwr_cnt;
    logic next_sleeping;

    assign awake = (pwr == BSAC_AWAKE);

    always_comb begin
        next_pwr = pwr;
        next_pwr_cnt = '0;
        unique case (pwr)
            BSAC_AWAKE: begin
                if (sleep_sync[1]) begin
                    next_pwr = BSAC_ENTER;
                end
            end
            BSAC_ENTER: begin
                next_pwr_cnt = 2'(pwr_cnt + BSAC_STEP_ONE);
                if (pwr_cnt == BSAC_SLEEP_CNT_MAX) begin
                    next_pwr = BSAC_ASLEEP;
                end
            end
            BSAC_ASLEEP: begin
                if (!sleep_sync[1]) begin
                    next_pwr = BSAC_LEAVE;
                end
            end
            BSAC_LEAVE: begin
                next_pwr_cnt = 2'(pwr_cnt + BSAC_STEP_ONE);
                if (pwr_cnt == BSAC_SLEEP_CNT_MAX) begin
                    next_pwr = BSAC_AWAKE;
                end
            end
        endcase
        if (!rst_n) begin
            next_pwr = BSAC_AWAKE;
            next_pwr_cnt = '0;
        end
        next_sleeping = (next_pwr != BSAC_AWAKE);
    end

    always_ff @(posedge mclk) begin
        pwr <= next_pwr;
        pwr_cnt <= next_pwr_cnt;
        sleeping <= next_sleeping;
    end

    // ------------------------------------------------------------
    // data output drive
    // ------------------------------------------------------------
    logic read_prev;
    logic next_read_prev;
    logic next_dq_oe;
    logic [BSAC_DATA_W-1:0] next_dq_out;

    always_comb begin
        // a read cycle in progress, excluding any detected write
        next_read_prev = awake && ((selected && (start_proc || start_ctrl) && !req.wr)
                         || (active && !req.wr && !(start_ctrl && !selected)
                             && !(start_proc && !selected)));
        // drive only after a full read cycle, never while writing
        next_dq_oe = next_read_prev && read_prev && !oe_sync[1] && !req.wr;
        if (!rst_n) begin
            next_read_prev = 1'b0;
            next_dq_oe = 1'b0;
        end
        next_dq_out = rd_word;
    end

    always_ff @(posedge mclk) begin
        read_prev <= next_read_prev;
        dq_oe <= next_dq_oe;
        dq_out <= next_dq_out;
    end
endmodule

// *** bench/bsac_assertions.sv ***
// Purpose: port checker for the burst sram access control
// Assumes: pins sampled on rising mclk, answer registered two edges later
// Notes: bound to bsac_top below by name, all pins but address, data, advance and order select
`timescale 1ns/1ns
module bsac_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bus master pins
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_high,
    input wire logic chip_sel_third_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic global_write_n,
    input wire logic byte_write_qualify_n,
    input wire logic [bsac_pkg::BSAC_LANES-1:0] byte_lane_select_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // outputs
    input wire logic dq_oe,
    input wire logic sleeping
);
    logic act;
    logic wr_start;
    logic desel;
    assign act = !chip_sel_primary_n && chip_sel_high && !chip_sel_third_n;
    assign wr_start = act && !controller_addr_strobe_n && processor_addr_strobe_n
        && (!global_write_n || (!byte_write_qualify_n && !(&byte_lane_select_n)));
    assign desel = !controller_addr_strobe_n && !act;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    oe_off_a: assert property (output_enable_n [*4] |-> !dq_oe)
        else $error("dq driven while oe high");
    oe_cause_a: assert property (dq_oe |-> !$past(output_enable_n, 3))
        else $error("dq driven without oe low");
    desel_off_a: assert property (desel [*3] |-> ##2 !dq_oe)
        else $error("dq driven while deselected");
    write_off_a: assert property (wr_start |-> ##2 !dq_oe)
        else $error("dq driven during write");
    sleep_on_a: assert property (sleep_request [*8] |-> sleeping)
        else $error("sleep not entered");
    sleep_rise_a: assert property ($rose(sleep_request) |-> ##[1:8] sleeping)
        else $error("sleep entry too slow");
    wake_a: assert property (!sleep_request [*8] |-> !sleeping)
        else $error("sleep not left");
    sleep_quiet_a: assert property (sleeping [*3] |-> !dq_oe)
        else $error("dq driven in sleep");
    cover property (wr_start);
    cover property ($rose(sleeping));
    cover property (dq_oe [*3]);
endmodule

bind bsac_top bsac_chk i_chk (.mclk(mclk), .rst_n(rst_n),
    .chip_sel_primary_n(chip_sel_primary_n), .chip_sel_high(chip_sel_high),
    .chip_sel_third_n(chip_sel_third_n), .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .global_write_n(global_write_n),
    .byte_write_qualify_n(byte_write_qualify_n), .byte_lane_select_n(byte_lane_select_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .dq_oe(dq_oe),
    .sleeping(sleeping));

// *** bench/bsac_master.sv ***
// Purpose: bus master model driving the sram pins
// Assumes: pins change 1 ns after the rising mclk edge
// Notes: undriven data toggles so stale values never look valid
`timescale 1ns/1ns
module bsac_master (
    // clock
    input wire logic mclk,
    // control pins
    output logic [2:0] sel,
    output logic [1:0] stb_n,
    output logic adv_n,
    output logic [5:0] we_n,
    output logic oe_n,
    output logic sleep_request,
    // address and data
    output logic [bsac_pkg::BSAC_ADDR_W-1:0] addr,
    output logic [bsac_pkg::BSAC_DATA_W-1:0] dq_in
);
    import bsac_pkg::*;
    logic wr;
    initial begin
        sel = 3'h5;
        stb_n = 2'h3;
        adv_n = 1'b1;
        we_n = 6'h3f;
        oe_n = 1'b1;
        sleep_request = 1'b0;
        addr = '0;
        dq_in = '0;
    end
    task automatic cyc(input logic [2:0] s, input logic [1:0] st, input logic av,
            input logic [5:0] w, input logic o, input logic [18:0] a, input logic [31:0] d);
        sel = s;
        stb_n = st;
        adv_n = av;
        we_n = w;
        addr = a;
        wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
        oe_n = o | wr;
        dq_in = wr ? d : ~dq_in;
        @(posedge mclk);
        #1;
    endtask
    task automatic doze(input int n);
        sel = 3'h5;
        stb_n = 2'h2;
        @(posedge mclk);
        #1;
        sleep_request = 1'b1;
        repeat (n) @(posedge mclk);
        #1;
        sleep_request = 1'b0;
        stb_n = 2'h3;
        repeat (BSAC_SLEEP_EXIT_GUARD_CYC + 6) @(posedge mclk);
        #1;
    endtask
endmodule

// *** bench/bsac_tb_top.sv ***
// Purpose: self-checking bench for the burst sram access control
// Assumes: read data one edge after the pins are sampled
// Notes: data checked through burst reads of four words at 0x100
`timescale 1ns/1ns
module bsac_tb_top;
    import bsac_pkg::*;
    localparam logic [2:0] ON = 3'h2;
    localparam logic [2:0] OFF = 3'h5;
    localparam logic [5:0] NOWR = 6'h3f;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic order = 1'b1;
    logic [2:0] sel;
    logic [1:0] stb_n;
    logic adv_n;
    logic [5:0] we_n;
    logic oe_n;
    logic sleep_request;
    logic [BSAC_ADDR_W-1:0] addr;
    logic [BSAC_DATA_W-1:0] dq_in;
    logic [BSAC_DATA_W-1:0] dq_out;
    logic dq_oe;
    logic sleeping;
    logic [31:0] mem [4];
    int mismatches = 0;
    int checked = 0;
    always #25 mclk = ~mclk;
    bsac_master i_master (.mclk(mclk), .sel(sel), .stb_n(stb_n), .adv_n(adv_n), .we_n(we_n),
        .oe_n(oe_n), .sleep_request(sleep_request), .addr(addr), .dq_in(dq_in));
    bsac_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .chip_sel_primary_n(sel[2]),
        .chip_sel_high(sel[1]), .chip_sel_third_n(sel[0]), .processor_addr_strobe_n(stb_n[1]),
        .controller_addr_strobe_n(stb_n[0]), .burst_advance_n(adv_n),
        .global_write_n(we_n[5]), .byte_write_qualify_n(we_n[4]),
        .byte_lane_select_n(we_n[3:0]), .output_enable_n(oe_n), .burst_order_sel(order),
        .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .sleeping(sleeping));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------
    // scenarios
    // ----------------------------------------------
    task automatic wr_ctrl(input int i, input logic [5:0] w, input logic [31:0] d);
        logic [31:0] m;
        m = !w[5] ? 32'hffffffff : {{8{!w[3]}}, {8{!w[2]}}, {8{!w[1]}}, {8{!w[0]}}};
        m = (w[5] && w[4]) ? 32'h0 : m;
        i_master.cyc(OFF, 2'h2, 1'b1, NOWR, 1'b1, 19'h0, 32'h0);
        i_master.cyc(ON, 2'h2, 1'b1, w, 1'b1, 19'h100 + 19'(i), d);
        mem[i] = (mem[i] & ~m) | (d & m);
    endtask
    task automatic t_writes();
        for (int i = 0; i < 4; i++)
            wr_ctrl(i, 6'h10, 32'h11111111 * (i + 1));
        wr_ctrl(1, 6'h2a, 32'hc3c3a5a5);
        wr_ctrl(2, 6'h30, 32'h5a5a5a5a);
        wr_ctrl(3, 6'h2f, 32'h66666666);
        $display("done writes");
    endtask
    task automatic t_proc();
        i_master.cyc(ON, 2'h1, 1'b1, 6'h1f, 1'b1, 19'h102, 32'hdead0000);
        i_master.cyc(ON, 2'h3, 1'b1, 6'h2e, 1'b1, 19'h102, 32'h0bad0f0e);
        mem[2] = {mem[2][31:8], 8'h0e};
        i_master.cyc(ON, 2'h0, 1'b1, 6'h1f, 1'b1, 19'h103, 32'h77777777);
        i_master.cyc(OFF, 2'h2, 1'b1, NOWR, 1'b1, 19'h0, 32'h0);
        $display("done processor strobe");
    endtask
    task automatic t_burst(input logic o);
        int k[5] = '{1, 1, 2, 3, 0};
        int hits;
        logic [7:0] oe_s;
        logic [31:0] dq_s [8];
        hits = 0;
        order = o;
        repeat (4) i_master.cyc(OFF, 2'h2, 1'b1, NOWR, 1'b0, 19'h0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            if (i == 0)
                i_master.cyc(ON, 2'h1, 1'b1, NOWR, 1'b0, 19'h101, 32'h0);
            else if (i < 5)
                i_master.cyc(ON, 2'h3, i == 2, NOWR, 1'b0, 19'h101, 32'h0);
            else
                i_master.cyc(OFF, 2'h2, 1'b1, NOWR, 1'b0, 19'h0, 32'h0);
            oe_s[i] = dq_oe;
            dq_s[i] = dq_out;
        end
        for (int i = 0; i < 5; i++) begin
            if (oe_s[i+2] === 1'b1) begin
                hits++;
                chk("burst data", mem[o ? (1 ^ k[i]) : ((1 + k[i]) & 3)], dq_s[i+2]);
            end
        end
        chk("burst oe", 32'h3c, {24'h0, oe_s});
        chk("burst beats", 32'h4, hits);
        $display("done burst order %0d", o);
    endtask
    task automatic t_sleep();
        fork
            i_master.doze(10);
            begin
                repeat (9) @(posedge mclk);
                #1;
                chk("sleeping", 32'h1, {31'h0, sleeping});
            end
        join
        chk("awake", 32'h0, {31'h0, sleeping});
        t_burst(1'b1);
        $display("done sleep");
    endtask
    initial begin
        repeat (1000) @(posedge mclk);
        mismatches++;
        $display("unexpected timeout: expected done seen hang");
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_writes();
        t_proc();
        t_burst(1'b0);
        t_burst(1'b1);
        t_sleep();
        end_of_test();
    end
endmodule
